/* File: isp_defines.svh */
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

// Register word indices on the Wishbone bus; byte address is four times the index.
`define ISP_IDX_SENSE 3'h0
`define ISP_IDX_ENABLE 3'h1
`define ISP_IDX_FLAGS 3'h2
`define ISP_IDX_PRIO_A 3'h3
`define ISP_IDX_PRIO_B 3'h4

// Reset values.
`define ISP_RST_SENSE 8'h00
`define ISP_RST_ENABLE 8'h00
`define ISP_RST_FLAGS 8'h00
`define ISP_RST_PRIO_A 8'h00
`define ISP_RST_PRIO_B 8'h00
`define ISP_RST_PIN_PREV 8'hFF

// Priority bit positions inside priority_group_b.
`define ISP_TIMER3_LEVEL_BIT 7
`define ISP_TIMER4_LEVEL_BIT 6
`define ISP_XFER_GROUP0_LEVEL_BIT 5
`define ISP_XFER_GROUP1_LEVEL_BIT 4
`define ISP_SERIAL0_LEVEL_BIT 3
`define ISP_SERIAL1_LEVEL_BIT 2
`define ISP_ADC_LEVEL_BIT 1
// Priority bit position inside priority_group_a.
`define ISP_TIMER2_LEVEL_BIT 0

// Source counts and the first external vector.
`define ISP_NUM_PINS 8
`define ISP_NUM_INT 34
`define ISP_NUM_SRC 42
`define ISP_EXT_VEC_BASE 8'h0C

// Internal source vectors, index 0 first, ascending.
`define ISP_INT_VECTORS {8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, \
	8'h24, 8'h25, 8'h26, 8'h28, 8'h29, 8'h2A, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, \
	8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C}

// Level bit of every source as a position in {priority_group_a, priority_group_b}.
`define ISP_EXT_LEVEL_POS {4'hF, 4'hE, 4'hD, 4'hD, 4'hC, 4'hC, 4'hC, 4'hC}
`define ISP_INT_LEVEL_POS {4'hB, 4'hB, 4'hA, 4'hA, 4'hA, 4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8, \
	4'h7, 4'h7, 4'h7, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h4, 4'h4, \
	4'h3, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1}

`endif

/* File: isp_pkg.sv */
package isp_pkg;

	typedef struct packed {
		logic valid;
		logic level;
		logic [7:0] vector;
	} isp_cpu_req_t;

	typedef struct packed {
		logic [7:0] prio_a;
		logic [7:0] prio_b;
		logic [7:0] sense;
		logic [7:0] enable;
		logic [7:0] flags;
		logic [7:0] armed;
		logic [7:0] pin_prev;
		logic wb_ack;
		logic [31:0] wb_dat;
		isp_cpu_req_t cpu;
		logic [7:0] ext_active;
	} isp_state_t;

endpackage

/* File: isp_irq_sense_priority.sv */
`timescale 1ns/10ps
`default_nettype none
`include "isp_defines.svh"

// Functional notes
// - prio_a bit 0 sets timer2 level.
// - prio_b bit 7 sets timer3 level.
// - prio_b bit 6 sets timer4 level.
// - prio_b bit 5 sets transfer group0 level.
// - prio_b bit 4 sets transfer group1 level.
// - prio_b bit 3 sets serial0 level.
// - prio_b bit 2 sets serial1 level.
// - prio_b bit 1 sets converter level.
// - prio_b bit 0 stores and reads back.
// - prio_b zero on reset and standby.
// - Level mode sets flag while pin low.
// - Edge mode sets flag on falling edge.
// - Flag cleared by read one, write zero.
// - Exception handling clears flag per mode.
// - Flag writes only clear, ones ignored.
// - Flags zero on reset and standby.
// - Enable bit n gates pin n.
// - Enables zero on reset and standby.
// - Sense bit: zero level, one edge.
// - Sense zero on reset and standby.
// - Eight pins plus 34 internal sources.
// - Same level: smaller vector wins.
// - Pins 0 to 7 use vectors 12-19.
module isp_irq_sense_priority
	import isp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic standby_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [4:2] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [7:0] ext_request_pin_n_i,
	input wire logic [33:0] int_req_i,
	input wire logic exc_ack_i,
	input wire logic [7:0] exc_ack_vec_i,
	output isp_cpu_req_t cpu_req_o,
	output logic [7:0] ext_active_o
);

	localparam logic [0:33][7:0] INT_VEC = `ISP_INT_VECTORS;
	localparam logic [0:7][3:0] EXT_LVL = `ISP_EXT_LEVEL_POS;
	localparam logic [0:33][3:0] INT_LVL = `ISP_INT_LEVEL_POS;

	isp_state_t st_r;
	isp_state_t st_nxt;

	logic access;
	logic wr_lo;
	logic [15:0] prio_all;
	logic [7:0] set_ev;
	logic [7:0] exc_clr;
	logic [7:0] sw_clr;
	logic [7:0] ev_vec;
	logic found_hi;
	logic found_lo;
	logic [7:0] vec_hi;
	logic [7:0] vec_lo;
	logic req;
	logic lvl;

	always_comb begin
		st_nxt = st_r;
		access = cyc_i && stb_i && !st_r.wb_ack;
		wr_lo = access && we_i && sel_i[0];
		prio_all = {st_r.prio_a, st_r.prio_b};
		set_ev = '0;
		exc_clr = '0;
		sw_clr = '0;
		found_hi = 1'b0;
		found_lo = 1'b0;
		vec_hi = '0;
		vec_lo = '0;
		req = 1'b0;
		lvl = 1'b0;
		ev_vec = '0;

		// Pin detection and flag clearing, one pin per pass.
		for (int n = 0; n < `ISP_NUM_PINS; n++) begin
			ev_vec = `ISP_EXT_VEC_BASE + 8'(n);
			if (!st_r.sense[n]) begin
				set_ev[n] = !ext_request_pin_n_i[n];
				exc_clr[n] = exc_ack_i && exc_ack_vec_i == ev_vec && ext_request_pin_n_i[n];
			end else begin
				set_ev[n] = st_r.pin_prev[n] && !ext_request_pin_n_i[n];
				exc_clr[n] = exc_ack_i && exc_ack_vec_i == ev_vec;
			end
			// A written zero clears only a flag that was read as one; a one leaves it alone.
			sw_clr[n] = wr_lo && adr_i == `ISP_IDX_FLAGS && !dat_i[n] && st_r.armed[n];
		end

		st_nxt.pin_prev = ext_request_pin_n_i;
		// The set wins over any clear in the same cycle.
		st_nxt.flags = (st_r.flags & ~(sw_clr | exc_clr)) | set_ev;
		st_nxt.armed = st_r.armed & st_nxt.flags & ~sw_clr;

		st_nxt.wb_ack = access;
		st_nxt.wb_dat = '0;
		if (access && !we_i) begin
			if (adr_i == `ISP_IDX_SENSE) begin
				st_nxt.wb_dat = {24'h000000, st_r.sense};
			end else if (adr_i == `ISP_IDX_ENABLE) begin
				st_nxt.wb_dat = {24'h000000, st_r.enable};
			end else if (adr_i == `ISP_IDX_FLAGS) begin
				st_nxt.wb_dat = {24'h000000, st_r.flags};
				st_nxt.armed = st_nxt.armed | (st_r.flags & st_nxt.flags);
			end else if (adr_i == `ISP_IDX_PRIO_A) begin
				st_nxt.wb_dat = {24'h000000, st_r.prio_a};
			end else if (adr_i == `ISP_IDX_PRIO_B) begin
				st_nxt.wb_dat = {24'h000000, st_r.prio_b};
			end
		end
		if (wr_lo) begin
			if (adr_i == `ISP_IDX_SENSE) begin
				st_nxt.sense = dat_i[7:0];
			end else if (adr_i == `ISP_IDX_ENABLE) begin
				st_nxt.enable = dat_i[7:0];
			end else if (adr_i == `ISP_IDX_PRIO_A) begin
				st_nxt.prio_a = dat_i[7:0];
			end else if (adr_i == `ISP_IDX_PRIO_B) begin
				st_nxt.prio_b = dat_i[7:0];
			end
		end

		// Sources are scanned in ascending vector order, so the first hit at a level is its winner.
		for (int i = 0; i < `ISP_NUM_SRC; i++) begin
			if (i < `ISP_NUM_PINS) begin
				req = st_r.flags[i] && st_r.enable[i];
				lvl = prio_all[EXT_LVL[i]];
				ev_vec = `ISP_EXT_VEC_BASE + 8'(i);
			end else begin
				req = int_req_i[i - `ISP_NUM_PINS];
				lvl = prio_all[INT_LVL[i - `ISP_NUM_PINS]];
				ev_vec = INT_VEC[i - `ISP_NUM_PINS];
			end
			if (req && lvl && !found_hi) begin
				found_hi = 1'b1;
				vec_hi = ev_vec;
			end
			if (req && !lvl && !found_lo) begin
				found_lo = 1'b1;
				vec_lo = ev_vec;
			end
		end
		st_nxt.cpu.valid = found_hi || found_lo;
		st_nxt.cpu.level = found_hi;
		st_nxt.cpu.vector = found_hi ? vec_hi : vec_lo;
		st_nxt.ext_active = st_r.flags & st_r.enable;

		// Hardware standby initialises every register just as reset does, outputs included,
		// so no request or bus answer computed from the old state leaks out after it.
		if (standby_i) begin
			st_nxt.prio_a = `ISP_RST_PRIO_A;
			st_nxt.prio_b = `ISP_RST_PRIO_B;
			st_nxt.sense = `ISP_RST_SENSE;
			st_nxt.enable = `ISP_RST_ENABLE;
			st_nxt.flags = `ISP_RST_FLAGS;
			st_nxt.armed = '0;
			st_nxt.pin_prev = `ISP_RST_PIN_PREV;
			st_nxt.wb_ack = 1'b0;
			st_nxt.wb_dat = '0;
			st_nxt.cpu = '0;
			st_nxt.ext_active = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r.prio_a <= `ISP_RST_PRIO_A;
			st_r.prio_b <= `ISP_RST_PRIO_B;
			st_r.sense <= `ISP_RST_SENSE;
			st_r.enable <= `ISP_RST_ENABLE;
			st_r.flags <= `ISP_RST_FLAGS;
			st_r.armed <= '0;
			st_r.pin_prev <= `ISP_RST_PIN_PREV;
			st_r.wb_ack <= 1'b0;
			st_r.wb_dat <= '0;
			st_r.cpu <= '0;
			st_r.ext_active <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dat_o = st_r.wb_dat;
	assign ack_o = st_r.wb_ack;
	assign cpu_req_o = st_r.cpu;
	assign ext_active_o = st_r.ext_active;

endmodule
`default_nettype wire

/* File: isp_irq_sense_priority_props.sv */
`timescale 1ns/10ps
`default_nettype none
module isp_props
	import isp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic standby_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic [33:0] int_req_i,
	input wire isp_cpu_req_t cpu_req_o,
	input wire logic [7:0] ext_active_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || standby_i);
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	a_ack_next: assert property (s_req |=> ack_o) else $error("ack missing");
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("data while idle");
	a_dat_upper: assert property (dat_o[31:8] == 24'h0) else $error("upper data set");
	a_ext_vector: assert property (cpu_req_o.valid && cpu_req_o.vector inside {[8'h0C:8'h13]}
		|-> ext_active_o[3'(cpu_req_o.vector - 8'h0C)]) else $error("pin vector without pin");
	a_no_source: assert property (!cpu_req_o.valid || ext_active_o != 8'h00 || $past(int_req_i) != 34'h0)
		else $error("request without source");
	a_int_vector: assert property ($past(int_req_i) == 34'h1 && !$past(rst_i) && !$past(standby_i)
		&& ext_active_o == 8'h00 |-> cpu_req_o.valid && cpu_req_o.vector == 8'h14) else $error("bad vector");
	a_standby_clear: assert property (disable iff (rst_i) standby_i
		|=> !ack_o && !cpu_req_o.valid && ext_active_o == 8'h00) else $error("standby not cleared");
endmodule
bind isp_irq_sense_priority isp_props i_props (.*);
`default_nettype wire

/* File: isp_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module isp_cpu_model
	import isp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic serve_i,
	input wire isp_cpu_req_t req_i,
	output logic ack_o,
	output logic [7:0] vec_o
);
	// While no valid request is being served the vector toggles, so a stale value never passes as a real one.
	always_ff @(posedge clk_i) begin
		ack_o <= !rst_i && serve_i && req_i.valid && !ack_o;
		vec_o <= rst_i ? 8'h5A : (serve_i && req_i.valid) ? req_i.vector : ~vec_o;
	end
endmodule
`default_nettype wire

/* File: isp_irq_sense_priority_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module isp_irq_sense_priority_tb;
	import isp_pkg::*;
	logic clk_i = 0, rst_i = 1, standby_i = 0, cyc = 0, stb = 0, we = 0, serve = 0, ack_o, exc_ack;
	logic [2:0] adr = 0;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat = 0, dat_o;
	logic [7:0] pins = 8'hFF, ext_active_o, q, exc_vec;
	logic [33:0] int_req = 0;
	isp_cpu_req_t cpu_req_o;
	int miscompares = 0, tests_run = 0;
	int idx[8] = '{8, 11, 14, 17, 21, 25, 29, 33};
	logic [7:0] vec[8] = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
	always #12.5 clk_i = ~clk_i;
	isp_irq_sense_priority i_dut (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .ext_request_pin_n_i(pins),
		.int_req_i(int_req), .exc_ack_i(exc_ack), .exc_ack_vec_i(exc_vec), .cpu_req_o(cpu_req_o),
		.ext_active_o(ext_active_o));
	isp_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .serve_i(serve), .req_i(cpu_req_o), .ack_o(exc_ack),
		.vec_o(exc_vec));
	task automatic give_verdict;
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [2:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o[7:0];
		{cyc, stb} <= 2'b00;
		if (n == 20) begin
			miscompares++;
			give_verdict();
		end
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		wb(a, 1'b0, 8'h00);
		chk(q, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) rd(3'(i), 8'h00);
		wb(3'h4, 1'b1, 8'hA5);
		rd(3'h4, 8'hA5);
		sel <= 4'h0;
		wb(3'h4, 1'b1, 8'h00);
		sel <= 4'h1;
		rd(3'h4, 8'hA5);
		wb(3'h0, 1'b1, 8'h02);
		wb(3'h1, 1'b1, 8'h03);
		pins <= 8'hFE;
		tick(3);
		@(posedge clk_i) pins <= 8'hFF;
		tick(2);
		chk(ext_active_o, 8'h01);
		chk(cpu_req_o.vector, 8'h0C);
		wb(3'h2, 1'b1, 8'h00);
		tick(2);
		chk(ext_active_o, 8'h01);
		rd(3'h2, 8'h01);
		wb(3'h2, 1'b1, 8'hFF);
		rd(3'h2, 8'h01);
		wb(3'h2, 1'b1, 8'h00);
		rd(3'h2, 8'h00);
		pins <= 8'hFD;
		tick(3);
		chk(ext_active_o, 8'h02);
		@(posedge clk_i) serve <= 1'b1;
		tick(6);
		chk(ext_active_o, 8'h00);
		@(posedge clk_i) serve <= 1'b0;
		pins <= 8'hFC;
		for (int i = 0; i < 8; i++) begin
			wb(i == 0 ? 3'h3 : 3'h4, 1'b1, i == 0 ? 8'h01 : 8'h01 << (8 - i));
			int_req <= 34'h1 << idx[i];
			tick(3);
			chk(cpu_req_o.vector, vec[i]);
			chk({7'h0, cpu_req_o.level}, 8'h01);
		end
		@(posedge clk_i) standby_i <= 1'b1;
		pins <= 8'hFF;
		@(posedge clk_i) standby_i <= 1'b0;
		int_req <= 34'h1;
		for (int i = 0; i < 5; i++) rd(3'(i), 8'h00);
		tick(1);
		chk(cpu_req_o.vector, 8'h14);
		give_verdict();
	end
endmodule
`default_nettype wire
